// file: design/lvdc_pkg.sv
package lvdc_pkg;
   // register byte addresses on the avalon-mm slave
   localparam logic [3:0] LVDC_ADDR_CONTROL = 4'h0;
   localparam logic [3:0] LVDC_ADDR_STATUS = 4'h4;
   // control register field positions
   localparam int LVDC_CTL_DETECTOR_ENABLE = 7;
   localparam int LVDC_CTL_REFERENCE_ENABLE = 6;
   localparam int LVDC_CTL_COMPARE_SOURCE_SELECT = 5;
   localparam int LVDC_CTL_RESERVED = 4;
   localparam int LVDC_CTL_RESET_LEVEL_SELECT = 3;
   localparam int LVDC_CTL_LV_RESET_ENABLE = 2;
   localparam int LVDC_CTL_FALL_IRQ_ENABLE = 1;
   localparam int LVDC_CTL_RISE_IRQ_ENABLE = 0;
   // status register field positions
   localparam int LVDC_STS_FALL_FLAG = 1;
   localparam int LVDC_STS_RISE_FLAG = 0;
   // values after reset and fixed masks
   localparam logic [7:0] LVDC_CONTROL_RESET = 8'hf4;
   localparam logic [7:0] LVDC_CONTROL_RESERVED_ONES = 8'h10;
   // bits that survive a low-voltage reset
   localparam logic [7:0] LVDC_CONTROL_KEEP_MASK = 8'hfc;
   localparam logic [7:0] LVDC_STATUS_RESERVED_ONES = 8'hfc;
endpackage

// file: design/lvdc_edge.sv
`timescale 1ns/100ps
// one-cycle pulse on the rising edge of a synchronous level
module lvdc_edge (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // level in, pulse out
   input wire logic level,
   output logic pulse
);
   logic prev;
   logic next_prev;

   always_comb begin
      next_prev = level;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end

   assign pulse = level & ~prev;
endmodule // lvdc_edge

// file: design/lvdc_top.sv
`timescale 1ns/100ps
// Behaviour
// [RL1] detector off: only power-on reset, rest ignored
// [RL2] software uses only supported control combinations
// [RL3] reference and source bits set per application
// [RL4] status bits 7..2 read one, unwritable
// [RL5] fall flag sets on falling threshold crossing
// [RL6] rise flag needs armed fall then rise
// [RL7] flag clears by zero write after read-one
// [RL8] low-voltage reset clears both status flags
// [RL9] control register field layout, bit 4 reads one
// [RL10] upper control bits survive low-voltage reset
// [RL11] fall flag with enable raises interrupt line
// [RL12] rise flag and interrupt rise together
// [RL13] writing one never sets a flag
module lvdc_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // analog comparators, levels synchronous to clk_sys
   input wire logic below_fall_level,
   input wire logic above_rise_level,
   input wire logic below_reset_level,
   // analog controls
   output logic detector_enable,
   output logic reference_enable,
   output logic compare_source_select,
   output logic reset_level_select,
   // reset and interrupt requests
   output logic lv_reset,
   output logic detect_irq_line
);
   logic [7:0] lv_control_reg;
   logic [7:0] next_lv_control_reg;
   logic fall_flag;
   logic next_fall_flag;
   logic rise_flag;
   logic next_rise_flag;
   logic rise_armed;
   logic next_rise_armed;
   logic seen_fall;
   logic next_seen_fall;
   logic seen_rise;
   logic next_seen_rise;
   logic ack;
   logic next_ack;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic lv_reset_q;
   logic next_lv_reset;
   logic irq_q;
   logic next_irq;
   logic fall_pulse;
   logic rise_pulse;
   logic det_on;
   logic lv_active;
   logic take;
   logic wr_ctl;
   logic wr_sts;
   logic rd_sts;

   lvdc_edge u_fall_edge (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .level(below_fall_level),
      .pulse(fall_pulse)
   );

   lvdc_edge u_rise_edge (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .level(above_rise_level),
      .pulse(rise_pulse)
   );

   // one wait state so read data can come from a flip-flop
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign take = (avs_read | avs_write) & ack;
   assign wr_ctl = take & avs_write
      & (avs_address == lvdc_pkg::LVDC_ADDR_CONTROL);
   assign wr_sts = take & avs_write
      & (avs_address == lvdc_pkg::LVDC_ADDR_STATUS);
   assign rd_sts = take & avs_read
      & (avs_address == lvdc_pkg::LVDC_ADDR_STATUS);

   assign det_on = lv_control_reg[lvdc_pkg::LVDC_CTL_DETECTOR_ENABLE];
   // reset and irq paths are dead while the detector is off
   assign lv_active = det_on & below_reset_level // RL1
      & lv_control_reg[lvdc_pkg::LVDC_CTL_LV_RESET_ENABLE];

   // bus handshake and read data
   always_comb begin
      next_ack = (avs_read | avs_write) & ~ack;
      next_rdata = rdata;
      if (avs_read & ~ack) begin
         case (avs_address)
            lvdc_pkg::LVDC_ADDR_CONTROL: begin
               next_rdata = lv_control_reg; // RL9
            end
            lvdc_pkg::LVDC_ADDR_STATUS: begin
               next_rdata = lvdc_pkg::LVDC_STATUS_RESERVED_ONES; // RL4
               next_rdata[lvdc_pkg::LVDC_STS_FALL_FLAG] = fall_flag;
               next_rdata[lvdc_pkg::LVDC_STS_RISE_FLAG] = rise_flag;
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ack <= 1'b0;
         rdata <= 8'h00;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   assign avs_readdata = {24'h000000, rdata};

   // control register
   always_comb begin
      next_lv_control_reg = lv_control_reg;
      if (wr_ctl) begin
         next_lv_control_reg = avs_writedata[7:0]
            | lvdc_pkg::LVDC_CONTROL_RESERVED_ONES; // RL9
      end
      if (lv_active) begin
         // only the interrupt enables fall back
         next_lv_control_reg = next_lv_control_reg
            & lvdc_pkg::LVDC_CONTROL_KEEP_MASK; // RL10
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lv_control_reg <= lvdc_pkg::LVDC_CONTROL_RESET;
      end else begin
         lv_control_reg <= next_lv_control_reg;
      end
   end

   // status flags, arming and read-before-clear tracking
   always_comb begin
      next_fall_flag = fall_flag;
      next_rise_flag = rise_flag;
      next_rise_armed = rise_armed;
      next_seen_fall = seen_fall;
      next_seen_rise = seen_rise;
      if (rd_sts) begin
         next_seen_fall = rdata[lvdc_pkg::LVDC_STS_FALL_FLAG]; // RL7
         next_seen_rise = rdata[lvdc_pkg::LVDC_STS_RISE_FLAG]; // RL7
      end
      if (wr_sts) begin
         // a written one leaves the flag alone
         if (!avs_writedata[lvdc_pkg::LVDC_STS_FALL_FLAG] && seen_fall) begin
            next_fall_flag = 1'b0; // RL7 RL13
            next_seen_fall = 1'b0;
         end
         if (!avs_writedata[lvdc_pkg::LVDC_STS_RISE_FLAG] && seen_rise) begin
            next_rise_flag = 1'b0; // RL7 RL13
            next_seen_rise = 1'b0;
         end
      end
      // hardware set beats a software clear in the same cycle
      if (det_on && fall_pulse) begin
         next_fall_flag = 1'b1; // RL5
         if (lv_control_reg[lvdc_pkg::LVDC_CTL_RISE_IRQ_ENABLE]) begin
            next_rise_armed = 1'b1; // RL6
         end
      end
      if (det_on && rise_pulse && rise_armed
          && lv_control_reg[lvdc_pkg::LVDC_CTL_RISE_IRQ_ENABLE]) begin
         next_rise_flag = 1'b1; // RL6
         next_rise_armed = 1'b0;
      end
      if (!det_on || below_reset_level) begin
         next_rise_armed = 1'b0; // RL6
      end
      if (lv_active) begin
         next_fall_flag = 1'b0; // RL8
         next_rise_flag = 1'b0; // RL8
         next_seen_fall = 1'b0;
         next_seen_rise = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fall_flag <= 1'b0;
         rise_flag <= 1'b0;
         rise_armed <= 1'b0;
         seen_fall <= 1'b0;
         seen_rise <= 1'b0;
      end else begin
         fall_flag <= next_fall_flag;
         rise_flag <= next_rise_flag;
         rise_armed <= next_rise_armed;
         seen_fall <= next_seen_fall;
         seen_rise <= next_seen_rise;
      end
   end

   // reset and interrupt requests, from next state so a flag and
   // its request appear on the same edge
   always_comb begin
      // a detector switched off in this cycle must not leave a reset
      next_lv_reset = lv_active
         & next_lv_control_reg[lvdc_pkg::LVDC_CTL_DETECTOR_ENABLE]; // RL1
      next_irq = next_lv_control_reg[lvdc_pkg::LVDC_CTL_DETECTOR_ENABLE]
         & ((next_fall_flag // RL11
         & next_lv_control_reg[lvdc_pkg::LVDC_CTL_FALL_IRQ_ENABLE])
         | (next_rise_flag // RL12
         & next_lv_control_reg[lvdc_pkg::LVDC_CTL_RISE_IRQ_ENABLE]));
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lv_reset_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         lv_reset_q <= next_lv_reset;
         irq_q <= next_irq;
      end
   end

   assign lv_reset = lv_reset_q;
   assign detect_irq_line = irq_q;
   // compare source and reset level selects are held off while the detector is off; reference_enable is not
   assign detector_enable = det_on;
   assign reference_enable =
      lv_control_reg[lvdc_pkg::LVDC_CTL_REFERENCE_ENABLE];
   assign compare_source_select = det_on // RL1
      & lv_control_reg[lvdc_pkg::LVDC_CTL_COMPARE_SOURCE_SELECT];
   assign reset_level_select = det_on // RL1
      & lv_control_reg[lvdc_pkg::LVDC_CTL_RESET_LEVEL_SELECT];

   AST_OFF_NO_IRQ: assert property (@(posedge clk_sys) // RL1
      disable iff (!rstn) !det_on |-> !detect_irq_line && !lv_reset)
      else $error("request active with detector off");
   AST_STATUS_RESERVED: assert property (@(posedge clk_sys) // RL4
      disable iff (!rstn) rd_sts |-> avs_readdata[7:2] == 6'h3f)
      else $error("reserved status bits not read as one");
   AST_FALL_SETS: assert property (@(posedge clk_sys) // RL5
      disable iff (!rstn) det_on && fall_pulse && !lv_active |=> fall_flag)
      else $error("fall flag missed a crossing");
   AST_RISE_NEEDS_ARM: assert property (@(posedge clk_sys) // RL6
      disable iff (!rstn) $rose(rise_flag) |-> $past(rise_armed)
      && $past(rise_pulse))
      else $error("rise flag set without armed fall");
   AST_CLEAR_NEEDS_READ: assert property (@(posedge clk_sys) // RL7
      disable iff (!rstn) $fell(fall_flag) |->
      $past(lv_active) || $past(seen_fall))
      else $error("fall flag cleared without prior read");
   AST_LVR_CLEARS: assert property (@(posedge clk_sys) // RL8
      disable iff (!rstn) lv_active |=> !fall_flag && !rise_flag)
      else $error("flags survived low-voltage reset");
   AST_CTRL_KEPT: assert property (@(posedge clk_sys) // RL10
      disable iff (!rstn) lv_active && !wr_ctl
      |=> lv_control_reg[7:2] == $past(lv_control_reg[7:2])
      && lv_control_reg[1:0] == 2'h0)
      else $error("control bits wrong after low-voltage reset");
   AST_FALL_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn) // RL11
      fall_flag && det_on && lv_control_reg[1] |-> detect_irq_line)
      else $error("fall interrupt not raised");
   AST_RISE_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn) // RL12
      $rose(rise_flag) |-> detect_irq_line)
      else $error("rise interrupt not raised with flag");
   AST_NO_SW_SET: assert property (@(posedge clk_sys) // RL13
      disable iff (!rstn) $rose(fall_flag)
      |-> $past(fall_pulse) && $past(det_on))
      else $error("fall flag set without a crossing");
endmodule // lvdc_top

// file: tb/lvdc_supply_model.sv
`timescale 1ns/100ps
// comparators and reference seen from the supply in millivolts
module lvdc_supply_model #(
   parameter int FALL_MV = 3700,
   parameter int RISE_MV = 4000,
   parameter int RST_LO_MV = 2300,
   parameter int RST_HI_MV = 3600
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // supply and analog controls
   input wire logic [15:0] supply_mv,
   input wire logic reference_enable,
   input wire logic reset_level_select,
   // comparator levels
   output logic below_fall_level,
   output logic above_rise_level,
   output logic below_reset_level
);
   logic [15:0] rst_mv;
   assign rst_mv = reset_level_select ? 16'(RST_HI_MV) : 16'(RST_LO_MV);
   // detector enable is not looked at: the block itself must ignore us
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn || !reference_enable) begin
         below_fall_level <= 1'b0;
         above_rise_level <= 1'b0;
         below_reset_level <= 1'b0;
      end else begin
         below_fall_level <= supply_mv < 16'(FALL_MV);
         above_rise_level <= supply_mv > 16'(RISE_MV);
         below_reset_level <= supply_mv < rst_mv;
      end
   end
endmodule // lvdc_supply_model

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   localparam logic [3:0] CTL = lvdc_pkg::LVDC_ADDR_CONTROL;
   localparam logic [3:0] STS = lvdc_pkg::LVDC_ADDR_STATUS;
   // four supported control combinations, first one in the top byte
   localparam logic [31:0] COMBOS = 32'hece2e3e7;
   logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic below_fall_level, above_rise_level, below_reset_level;
   logic detector_enable, reference_enable, compare_source_select;
   logic reset_level_select, lv_reset, detect_irq_line;
   logic [15:0] supply_mv;
   logic [7:0] rd;
   logic [7:0] combo;
   int mismatches, compares;

   lvdc_top i_lvdc_top (.clk_sys(clk_sys), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .below_fall_level(below_fall_level),
      .above_rise_level(above_rise_level),
      .below_reset_level(below_reset_level),
      .detector_enable(detector_enable), .reference_enable(reference_enable),
      .compare_source_select(compare_source_select),
      .reset_level_select(reset_level_select), .lv_reset(lv_reset),
      .detect_irq_line(detect_irq_line));
   lvdc_supply_model i_lvdc_supply_model (.clk_sys(clk_sys), .rstn(rstn),
      .supply_mv(supply_mv), .reference_enable(reference_enable),
      .reset_level_select(reset_level_select),
      .below_fall_level(below_fall_level),
      .above_rise_level(above_rise_level),
      .below_reset_level(below_reset_level));

   always #4 clk_sys = ~clk_sys;

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // holds the request until waitrequest is sampled low at an edge
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= ~w;
      avs_write <= w;
      avs_writedata <= {24'h0, d};
      // only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [3:0] a,
                        input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(what, exp, rd);
   endtask

   // comparator register, edge pulse, then flag: settled well within 4
   task automatic supply(input logic [15:0] mv);
      @(posedge clk_sys);
      supply_mv <= mv;
      repeat (4) @(posedge clk_sys);
   endtask

   initial begin
      {clk_sys, rstn, avs_read, avs_write} = 4'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      supply_mv = 16'd5000;
      mismatches = 0;
      compares = 0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      rdchk("ctl reset", CTL, 8'hf4);
      rdchk("sts reset", STS, 8'hfc);
      bus(1'b1, STS, 8'hff);
      rdchk("sts write ones", STS, 8'hfc);
      rdchk("unmapped", 4'h8, 8'h00);
      bus(1'b1, 4'h8, 8'h00);
      rdchk("ctl unmapped write", CTL, 8'hf4);
      $display("test reset_values done");
      for (int i = 0; i < 4; i++) begin
         combo = COMBOS[31 - 8 * i -: 8];
         bus(1'b1, CTL, combo);
         rdchk("ctl readback", CTL, combo | 8'h10);
         chk("selects", {4'h0, combo[7:5], combo[3]}, {4'h0,
             detector_enable, reference_enable, compare_source_select,
             reset_level_select});
      end
      $display("test combos done");
      supply(16'd3000);
      chk("irq fall", 8'h01, {7'h0, detect_irq_line});
      rdchk("sts fall", STS, 8'hfe);
      supply(16'd4500);
      rdchk("sts rise", STS, 8'hff);
      bus(1'b1, STS, 8'hfe);
      rdchk("rise cleared", STS, 8'hfe);
      bus(1'b1, STS, 8'h00);
      rdchk("both cleared", STS, 8'hfc);
      chk("irq cleared", 8'h00, {7'h0, detect_irq_line});
      supply(16'd3000);
      supply(16'd4500);
      bus(1'b1, STS, 8'h00);
      rdchk("zero write unread", STS, 8'hff);
      bus(1'b1, STS, 8'h00);
      rdchk("cleared after read", STS, 8'hfc);
      // reset threshold crossed with the reset off: the arm must drop
      bus(1'b1, CTL, 8'he3);
      supply(16'd2000);
      supply(16'd4500);
      rdchk("no rise below reset", STS, 8'hfe);
      bus(1'b1, STS, 8'h00);
      rdchk("fall cleared", STS, 8'hfc);
      $display("test flags done");
      bus(1'b1, CTL, 8'hc7);
      supply(16'd3000);
      supply(16'd2000);
      chk("lv reset on", 8'h01, {7'h0, lv_reset});
      rdchk("sts lv reset", STS, 8'hfc);
      rdchk("ctl kept", CTL, 8'hd4);
      supply(16'd5000);
      chk("lv reset off", 8'h00, {7'h0, lv_reset});
      rdchk("no rise after lv", STS, 8'hfc);
      $display("test lv_reset done");
      bus(1'b1, CTL, 8'h67);
      rdchk("ctl off", CTL, 8'h77);
      supply(16'd3000);
      supply(16'd2000);
      chk("outputs off", 8'h00, {4'h0, lv_reset, detect_irq_line,
          compare_source_select, reset_level_select});
      chk("analog off", 8'h01, {6'h0, detector_enable, reference_enable});
      rdchk("sts off", STS, 8'hfc);
      $display("test detector_off done");
      supply(16'd5000);
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      rdchk("ctl after reset", CTL, 8'hf4);
      rdchk("sts after reset", STS, 8'hfc);
      $display("test mid_reset done");
      end_sim();
   end

   // the tests need about 200 cycles; this leaves a wide margin
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      $display("watchdog expired");
      end_sim();
   end
endmodule // tb_top
